// *** wst_select_tree.sv ***
`timescale 1ns/10ps
module wst_select_tree (
  // Clock and reset.
  input  wire logic                       core_clk,
  input  wire logic                       arst_n,
  // Selector configuration.
  input  wire wst_pkg::wst_width_e        widthSel,
  input  wire logic                       gatedMode,
  input  wire logic                       enable,
  // Data and select code.
  input  wire logic [wst_pkg::DATA_W-1:0] dataIn,
  input  wire logic [wst_pkg::SEL_W-1:0]  selCode,
  // Registered results.
  output logic                            generalOut,
  output logic                            cascadeFeed
);

  // Elementary two-input select stage.
  function automatic logic selStage(input logic firstChoice, input logic secondChoice,
                                    input logic sel);
    selStage = sel ? secondChoice : firstChoice;
  endfunction

  wst_pkg::wst_state_s state_q;
  wst_pkg::wst_state_s state_d;

  // Builds the tree level by level and picks the result for the active width.
  always_comb begin
    logic [wst_pkg::L1_N-1:0] lvl1;
    logic [wst_pkg::L2_N-1:0] lvl2;
    logic [wst_pkg::L3_N-1:0] lvl3;
    logic [wst_pkg::L4_N-1:0] lvl4;
    logic                     lvl5;
    logic [wst_pkg::L2_N-1:0] feed2;
    logic [wst_pkg::L3_N-1:0] feed3;
    logic [wst_pkg::L4_N-1:0] feed4;
    logic                     feed5;
    logic                     gateL1;
    logic                     gateTop;
    logic                     result;
    logic                     resultFeed;
    lvl1       = '0;
    lvl2       = '0;
    lvl3       = '0;
    lvl4       = '0;
    lvl5       = 1'h0;
    feed2      = '0;
    feed3      = '0;
    feed4      = '0;
    feed5      = 1'h0;
    result     = 1'h0;
    resultFeed = 1'h0;
    // Dedicated stages have no enable, so the gate sits in a lookup stage: the first level
    // for four and eight ways, the final stage (built as lookup) for the other widths.
    gateL1  = !(gatedMode && !enable &&
                (widthSel == wst_pkg::WAY4 || widthSel == wst_pkg::WAY8));
    gateTop = !(gatedMode && !enable && (widthSel == wst_pkg::WAY2 ||
                widthSel == wst_pkg::WAY16 || widthSel == wst_pkg::WAY32));
    // Lookup level: one two-input stage per data pair, driven by select bit zero.
    for (int i = 0; i < wst_pkg::L1_N; i++) begin
      lvl1[i] = selStage(dataIn[2*i], dataIn[2*i+1], selCode[0]) & gateL1;
    end
    // Dedicated levels: each stage gives a general and a cascade output, and the next
    // level takes its inputs from the cascade outputs through the local feedback path.
    for (int i = 0; i < wst_pkg::L2_N; i++) begin
      lvl2[i]  = selStage(lvl1[2*i], lvl1[2*i+1], selCode[1]);
      feed2[i] = selStage(lvl1[2*i], lvl1[2*i+1], selCode[1]);
    end
    for (int i = 0; i < wst_pkg::L3_N; i++) begin
      lvl3[i]  = selStage(feed2[2*i], feed2[2*i+1], selCode[2]);
      feed3[i] = selStage(feed2[2*i], feed2[2*i+1], selCode[2]);
    end
    for (int i = 0; i < wst_pkg::L4_N; i++) begin
      lvl4[i]  = selStage(feed3[2*i], feed3[2*i+1], selCode[3]);
      feed4[i] = selStage(feed3[2*i], feed3[2*i+1], selCode[3]);
    end
    // The top select bit chooses between the lower and the upper half.
    lvl5  = selStage(feed4[0], feed4[1], selCode[4]);
    feed5 = selStage(feed4[0], feed4[1], selCode[4]);
    // The output stage of each width uses its own top select bit only.
    case (widthSel)
      wst_pkg::WAY2: begin
        result     = lvl1[0];
        resultFeed = lvl1[0];
      end
      wst_pkg::WAY4: begin
        result     = lvl2[0];
        resultFeed = feed2[0];
      end
      wst_pkg::WAY8: begin
        result     = lvl3[0];
        resultFeed = feed3[0];
      end
      wst_pkg::WAY16: begin
        result     = lvl4[0];
        resultFeed = feed4[0];
      end
      wst_pkg::WAY32: begin
        result     = lvl5;
        resultFeed = feed5;
      end
      default: begin
        result     = 1'h0;
        resultFeed = 1'h0;
      end
    endcase
    state_d.generalOut  = result & gateTop;
    state_d.cascadeFeed = resultFeed & gateTop;
  end

  // Registers the selected bit on both outputs.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= '{generalOut: wst_pkg::RST_OUT, cascadeFeed: wst_pkg::RST_OUT};
    end else begin
      state_q <= state_d;
    end
  end

  assign generalOut  = state_q.generalOut;
  assign cascadeFeed = state_q.cascadeFeed;

  // Reference index: the select code cut to the width in use.
  logic [wst_pkg::SEL_W-1:0] refIdx;
  always_comb begin
    case (widthSel)
      wst_pkg::WAY2:  refIdx = {4'h0, selCode[0]};
      wst_pkg::WAY4:  refIdx = {3'h0, selCode[1:0]};
      wst_pkg::WAY8:  refIdx = {2'h0, selCode[2:0]};
      wst_pkg::WAY16: refIdx = {1'h0, selCode[3:0]};
      default:        refIdx = selCode;
    endcase
  end
  // Width codes beyond the widest select nothing, so the reference bit is zero there.
  logic refBit;
  assign refBit = (widthSel <= wst_pkg::WAY32) ? dataIn[refIdx] : 1'h0;
  logic offNow;
  assign offNow = gatedMode && !enable;

  property p_two_way;
    @(posedge core_clk) disable iff (!arst_n)
      (widthSel == wst_pkg::WAY2 && !offNow) |=>
        generalOut == $past(selCode[0] ? dataIn[1] : dataIn[0]);
  endproperty
  a_two_way: assert property (p_two_way) else $error("Two-way stage picked wrong input.");

  property p_outputs_equal;
    @(posedge core_clk) disable iff (!arst_n) cascadeFeed == generalOut;
  endproperty
  a_outputs_equal: assert property (p_outputs_equal) else $error("Outputs disagree.");

  property p_index_pick;
    @(posedge core_clk) disable iff (!arst_n) !offNow |=> generalOut == $past(refBit);
  endproperty
  a_index_pick: assert property (p_index_pick) else $error("Wrong input selected.");

  property p_cascade_pick;
    @(posedge core_clk) disable iff (!arst_n) !offNow |=> cascadeFeed == $past(refBit);
  endproperty
  a_cascade_pick: assert property (p_cascade_pick) else $error("Cascade wrong.");

  property p_four_way_top;
    @(posedge core_clk) disable iff (!arst_n)
      (widthSel == wst_pkg::WAY4 && selCode[1:0] == 2'h3 && !offNow) |=>
        generalOut == $past(dataIn[3]);
  endproperty
  a_four_way_top: assert property (p_four_way_top) else $error("Code 11 not input 3.");

  property p_width_mask;
    @(posedge core_clk) disable iff (!arst_n)
      (widthSel == wst_pkg::WAY8 && !offNow) |=> generalOut == $past(dataIn[selCode[2:0]]);
  endproperty
  a_width_mask: assert property (p_width_mask) else $error("Upper select bits used.");

  property p_gated_low;
    @(posedge core_clk) disable iff (!arst_n) offNow |=> !generalOut && !cascadeFeed;
  endproperty
  a_gated_low: assert property (p_gated_low) else $error("Disabled output not low.");

  property p_gated_small;
    @(posedge core_clk) disable iff (!arst_n)
      (offNow && (widthSel == wst_pkg::WAY4 || widthSel == wst_pkg::WAY8)) ##1 !offNow
        |=> generalOut == $past(refBit);
  endproperty
  a_gated_small: assert property (p_gated_small) else $error("Re-enable failed.");

  property p_gated_sixteen;
    @(posedge core_clk) disable iff (!arst_n)
      (offNow && widthSel == wst_pkg::WAY16) |=> !generalOut;
  endproperty
  a_gated_sixteen: assert property (p_gated_sixteen) else $error("16-way not gated.");

  property p_upper_half;
    @(posedge core_clk) disable iff (!arst_n)
      (widthSel == wst_pkg::WAY16 && selCode[3] && !offNow) |=>
        generalOut == $past(dataIn[{2'h1, selCode[2:0]}]);
  endproperty
  a_upper_half: assert property (p_upper_half) else $error("Top bit not upper half.");

  property p_wide_tree;
    @(posedge core_clk) disable iff (!arst_n)
      (widthSel == wst_pkg::WAY32 && !offNow) |=> generalOut == $past(dataIn[selCode]);
  endproperty
  a_wide_tree: assert property (p_wide_tree) else $error("32-way tree wrong.");

  // The cascade output of the two-way stage follows the same choice as the general one.
  property p_two_way_cascade;
    @(posedge core_clk) disable iff (!arst_n)
      (widthSel == wst_pkg::WAY2 && !offNow) |=>
        cascadeFeed == $past(selCode[0] ? dataIn[1] : dataIn[0]);
  endproperty
  a_two_way_cascade: assert property (p_two_way_cascade)
    else $error("Two-way cascade picked wrong input.");

  // Code zero of the four-way selector routes the first data input.
  property p_four_way_low;
    @(posedge core_clk) disable iff (!arst_n)
      (widthSel == wst_pkg::WAY4 && selCode[1:0] == 2'h0 && !offNow) |=>
        generalOut == $past(dataIn[0]);
  endproperty
  a_four_way_low: assert property (p_four_way_low)
    else $error("Code 00 not input 0.");

  // Every four-way code routes the input with the same unsigned number.
  property p_four_way_pick;
    @(posedge core_clk) disable iff (!arst_n)
      (widthSel == wst_pkg::WAY4 && !offNow) |=>
        generalOut == $past(dataIn[{3'h0, selCode[1:0]}]);
  endproperty
  a_four_way_pick: assert property (p_four_way_pick)
    else $error("Four-way index wrong.");

  // The sixteen-way selector uses four select bits and the lower sixteen inputs.
  property p_sixteen_pick;
    @(posedge core_clk) disable iff (!arst_n)
      (widthSel == wst_pkg::WAY16 && !offNow) |=>
        generalOut == $past(dataIn[{1'h0, selCode[3:0]}]);
  endproperty
  a_sixteen_pick: assert property (p_sixteen_pick)
    else $error("Sixteen-way index wrong.");

  // A low top bit keeps the sixteen-way result in the lower half.
  property p_lower_half;
    @(posedge core_clk) disable iff (!arst_n)
      (widthSel == wst_pkg::WAY16 && !selCode[3] && !offNow) |=>
        generalOut == $past(dataIn[{2'h0, selCode[2:0]}]);
  endproperty
  a_lower_half: assert property (p_lower_half)
    else $error("Top bit low not lower half.");

  // A high top bit moves the thirty-two-way result into the upper half.
  property p_wide_upper;
    @(posedge core_clk) disable iff (!arst_n)
      (widthSel == wst_pkg::WAY32 && selCode[4] && !offNow) |=>
        generalOut == $past(dataIn[{1'h1, selCode[3:0]}]);
  endproperty
  a_wide_upper: assert property (p_wide_upper)
    else $error("Top bit high not upper half.");

  // Width codes beyond the widest leave both outputs low.
  property p_bad_width;
    @(posedge core_clk) disable iff (!arst_n)
      (widthSel > wst_pkg::WAY32) |=> !generalOut && !cascadeFeed;
  endproperty
  a_bad_width: assert property (p_bad_width)
    else $error("Unused width code not low.");

  // The eight-way gated selector is held low through its first-level gate.
  property p_eight_way_gated;
    @(posedge core_clk) disable iff (!arst_n)
      (offNow && widthSel == wst_pkg::WAY8) |=>
        !generalOut && !cascadeFeed;
  endproperty
  a_eight_way_gated: assert property (p_eight_way_gated)
    else $error("Eight-way not gated.");

  // Gating at the final stage also holds the cascade output low.
  property p_gated_wide_feed;
    @(posedge core_clk) disable iff (!arst_n)
      (offNow && (widthSel == wst_pkg::WAY2 || widthSel == wst_pkg::WAY32)) |=>
        !cascadeFeed;
  endproperty
  a_gated_wide_feed: assert property (p_gated_wide_feed)
    else $error("Gated cascade not low.");

  // The sixteen-way final stage gates the cascade output as well.
  property p_gated_sixteen_feed;
    @(posedge core_clk) disable iff (!arst_n)
      (offNow && widthSel == wst_pkg::WAY16) |=> !cascadeFeed;
  endproperty
  a_gated_sixteen_feed: assert property (p_gated_sixteen_feed)
    else $error("Sixteen-way cascade not gated.");

  // Main scenarios.
  c_wide_high: cover property (@(posedge core_clk) disable iff (!arst_n)
    widthSel == wst_pkg::WAY32 && selCode == 5'h1F ##1 generalOut);
  c_gated_off: cover property (@(posedge core_clk) disable iff (!arst_n)
    offNow && dataIn != '0 ##1 !generalOut);
  c_four_way: cover property (@(posedge core_clk) disable iff (!arst_n)
    widthSel == wst_pkg::WAY4 && selCode[1:0] == 2'h3 ##1 generalOut);
  c_sixteen_gated: cover property (@(posedge core_clk) disable iff (!arst_n)
    offNow && widthSel == wst_pkg::WAY16 && dataIn[15:0] != '0 ##1 !generalOut);
  c_eight_reenable: cover property (@(posedge core_clk) disable iff (!arst_n)
    widthSel == wst_pkg::WAY8 && offNow ##1 !offNow ##1 generalOut);

endmodule

// *** wst_pkg.sv ***
// Shared constants and types for the wide select tree.
package wst_pkg;

  // Data and select widths of the widest selector.
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SEL_W  = 5;

  // Number of results produced at each level of the tree.
  localparam int unsigned L1_N = 16;
  localparam int unsigned L2_N = 8;
  localparam int unsigned L3_N = 4;
  localparam int unsigned L4_N = 2;

  // Reset value of the registered outputs.
  localparam logic RST_OUT = 1'h0;

  // Selector width in use.
  typedef enum logic [2:0] {
    WAY2,
    WAY4,
    WAY8,
    WAY16,
    WAY32
  } wst_width_e;

  // Registered state of the selector.
  typedef struct packed {
    logic generalOut;
    logic cascadeFeed;
  } wst_state_s;

endpackage

// *** wst_user_sink.sv ***
`timescale 1ns/10ps
// Downstream user logic that registers the selector results.
module wst_user_sink (
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic arst_n,
  // Selector results.
  input  wire logic generalOut,
  input  wire logic cascadeFeed,
  // Captured results.
  output logic      capturedOut,
  output logic      pathSplit
);
  // Captures the result and flags any split between the two output paths.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      capturedOut <= 1'h0;
      pathSplit   <= 1'h0;
    end else begin
      capturedOut <= generalOut;
      pathSplit   <= generalOut ^ cascadeFeed;
    end
  end
endmodule

// *** wide_select_tree_tb.sv ***
`timescale 1ns/10ps
module wide_select_tree_tb;
  logic                       core_clk;
  logic                       arst_n;
  logic                       gatedMode;
  logic                       enable;
  logic                       generalOut;
  logic                       cascadeFeed;
  logic                       expOut;
  logic                       expPrev;
  logic                       capturedOut;
  logic                       pathSplit;
  wst_pkg::wst_width_e        widthSel;
  logic [wst_pkg::DATA_W-1:0] dataIn;
  logic [wst_pkg::SEL_W-1:0]  selCode;
  logic [31:0]                rnd;
  int                         bad_count;
  int                         n_compared;

  // Design and the downstream user logic.
  wst_select_tree i_wst_select_tree (.core_clk(core_clk), .arst_n(arst_n),
    .widthSel(widthSel), .gatedMode(gatedMode), .enable(enable), .dataIn(dataIn),
    .selCode(selCode), .generalOut(generalOut), .cascadeFeed(cascadeFeed));
  wst_user_sink i_wst_user_sink (.core_clk(core_clk), .arst_n(arst_n),
    .generalOut(generalOut), .cascadeFeed(cascadeFeed), .capturedOut(capturedOut),
    .pathSplit(pathSplit));

  // Clock at 25 MHz.
  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end

  // Next value of the stimulus shift register.
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'h0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
  endfunction

  // Expected selected bit; widths beyond the widest give zero.
  function automatic logic pick(input logic [2:0] w, input logic g, input logic e,
                                input logic [31:0] d, input logic [4:0] s);
    if (w > 3'h4 || (g && !e)) return 1'h0;
    return d[s & (5'h1F >> (3'h4 - w))];
  endfunction

  // Compares one result bit.
  task automatic chk(input string name, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask

  // Checks the result of the previous cycle, then drives the next inputs.
  task automatic step(input logic [2:0] w, input logic g, input logic e,
                      input logic [31:0] d, input logic [4:0] s);
    @(negedge core_clk);
    chk("generalOut", expOut, generalOut);
    chk("cascadeFeed", expOut, cascadeFeed);
    chk("capturedOut", expPrev, capturedOut);
    chk("pathSplit", 1'h0, pathSplit);
    expPrev   = expOut;
    widthSel  = wst_pkg::wst_width_e'(w);
    gatedMode = g;
    enable    = e;
    dataIn    = d;
    selCode   = s;
    expOut    = pick(w, g, e, d, s);
  endtask

  // Prints the verdict and ends the run.
  task automatic conclude();
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Main sequence: corner cases for every width, then random traffic.
  initial begin
    arst_n = 1'h0;
    widthSel = wst_pkg::WAY2;
    {gatedMode, enable, dataIn, selCode} = '0;
    expOut = 1'h0;
    expPrev = 1'h0;
    rnd = 32'h34E1;
    bad_count = 0;
    n_compared = 0;
    repeat (20) @(negedge core_clk);
    arst_n = 1'h1;
    step(3'h1, 1'h0, 1'h0, 32'h8, 5'h3);
    step(3'h1, 1'h0, 1'h0, 32'h8, 5'h1F);
    for (int w = 0; w < 5; w++) begin
      step(3'(w), 1'h0, 1'h0, 32'h1 << ((2 << w) - 1), 5'h1F);
      step(3'(w), 1'h0, 1'h0, ~(32'h1 << ((2 << w) - 1)), 5'h1F);
      step(3'(w), 1'h1, 1'h0, 32'hFFFFFFFF, 5'(w));
      step(3'(w), 1'h1, 1'h1, 32'h1, 5'h0);
    end
    repeat (600) begin
      rnd = lfsr(rnd);
      step(rnd[2:0], rnd[3], rnd[4] | rnd[5], lfsr(rnd ^ 32'h5A5A), rnd[10:6]);
    end
    step(3'h0, 1'h0, 1'h0, 32'h0, 5'h0);
    conclude();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    #(40 * 2000);
    bad_count++;
    conclude();
  end
endmodule
